// ### sfid_readout.sv
// identification read-out logic behind the serial flash pins
`timescale 1ns/1ps
`default_nettype none
module sfid_readout #(
	parameter logic [7:0] MAKER_CODE = sfid_pkg::DEF_MAKER,
	parameter logic [7:0] MEM_TYPE   = sfid_pkg::DEF_TYPE,
	parameter logic [7:0] MEM_CAP    = sfid_pkg::DEF_CAPACITY,
	parameter logic [7:0] PART_CODE  = sfid_pkg::DEF_PART
) (
	// system
	input  wire logic clk,
	input  wire logic rstn,
	// serial link pins
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic si,
	output var  logic so_o,
	output var  logic so_oe_n,
	// device context
	input  wire logic busy,
	// delivered contents
	output var  logic [7:0] status_q,
	output var  logic [7:0] array_byte_q
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] cs_s;   // chip select two-flop chain
	logic [1:0] ck_s;   // serial clock chain
	logic [1:0] si_s;   // serial input chain
	logic       ck_d1;  // last synced clock, for edge finding
	logic       cs_d1;  // last synced select
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_s  <= 2'h3;
			ck_s  <= 2'h0;
			si_s  <= 2'h0;
			ck_d1 <= 1'b0;
			cs_d1 <= 1'b1;
		end
		else
		begin
			cs_s  <= {cs_s[0], cs_n};
			ck_s  <= {ck_s[0], sclk};
			si_s  <= {si_s[0], si};
			ck_d1 <= ck_s[1];
			cs_d1 <= cs_s[1];
		end
	end
	// only second stages are read beyond this point
	logic sel;
	logic rise;
	logic fall;
	logic desel;
	assign sel   = !cs_s[1];
	assign rise  = sel && ck_s[1] && !ck_d1;
	assign fall  = sel && !ck_s[1] && ck_d1;
	assign desel = cs_s[1] && !cs_d1;

	// ****************************************
	// command sequencer
	// ****************************************
	sfid_pkg::sfid_state_t st_q;
	logic [4:0]  cnt_q;   // bits taken, or given in the pair phase
	logic [23:0] sh_q;    // input shift
	logic [23:0] out_q;   // output shift
	logic        part_first_q;
	logic        lead_q;  // next fall only confirms the set-up bit
	logic [7:0]  opc;
	logic [23:0] addr;
	// decode views include the bit arriving on this very edge
	assign opc  = {sh_q[6:0], si_s[1]};
	assign addr = {sh_q[22:0], si_s[1]};

	// returns the two-byte pair for the maker/part command
	function automatic logic [15:0] mp_pair(input logic pfirst);
		mp_pair = pfirst ? {PART_CODE, MAKER_CODE}
			: {MAKER_CODE, PART_CODE};
	endfunction

	// phase, counter and shift registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q         <= sfid_pkg::SFID_OPC;
			cnt_q        <= 5'h00;
			sh_q         <= 24'h000000;
			out_q        <= 24'h000000;
			part_first_q <= 1'b0;
			lead_q       <= 1'b0;
		end
		else if (!sel)
		begin
			// deselect ends any phase, back to standby
			st_q  <= sfid_pkg::SFID_OPC;
			cnt_q <= 5'h00;
		end
		else
		begin
			case (st_q)
				sfid_pkg::SFID_OPC:
				if (rise)
				begin
					sh_q  <= {sh_q[22:0], si_s[1]};
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'(sfid_pkg::OPCODE_BITS - 1))
					begin
						cnt_q <= 5'h00;
						if (opc == sfid_pkg::CMD_MAKER_PART)
							st_q <= sfid_pkg::SFID_ADDR;
						else if (opc == sfid_pkg::CMD_FULL_ID && !busy)
						begin
							// busy: not decoded, cycle untouched
							st_q  <= sfid_pkg::SFID_OUT_ID;
							out_q <= {MAKER_CODE, MEM_TYPE,
								MEM_CAP};
							lead_q <= 1'b1;
						end
						else
							st_q <= sfid_pkg::SFID_IGNORE;
					end
				end
				sfid_pkg::SFID_ADDR:
				if (rise)
				begin
					sh_q  <= addr;
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'(sfid_pkg::ADDR_BITS - 1))
					begin
						// lowest address bit picks first byte
						part_first_q <= addr[0];
						out_q <= {mp_pair(addr[0]), 8'h00};
						st_q  <= sfid_pkg::SFID_OUT_MP;
						// restart the pair count for the output phase
						cnt_q  <= 5'h00;
						lead_q <= 1'b1;
					end
				end
				sfid_pkg::SFID_OUT_MP:
				if (fall && lead_q)
				begin
					// fall after the last input bit opens the window;
					// the first bit already stands on the pin
					lead_q <= 1'b0;
				end
				else if (fall)
				begin
					// pair repeats while clocking continues
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q[3:0] == 4'hf)
						out_q <= {mp_pair(part_first_q), 8'h00};
					else
						out_q <= {out_q[22:0], 1'b0};
				end
				sfid_pkg::SFID_OUT_ID:
				if (fall && lead_q)
				begin
					// same hold-off as the pair phase
					lead_q <= 1'b0;
				end
				else if (fall)
					out_q <= {out_q[22:0], 1'b0};
				sfid_pkg::SFID_IGNORE: ;
				default: st_q <= sfid_pkg::SFID_IGNORE;
			endcase
		end
	end

	// ****************************************
	// serial output driver
	// ****************************************
	// data changes on falling edges, first bit set up at phase entry
	logic out_phase;
	assign out_phase = sel && (st_q == sfid_pkg::SFID_OUT_MP
		|| st_q == sfid_pkg::SFID_OUT_ID);
	// registered so the pin never glitches between edges
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			so_o    <= 1'b0;
			so_oe_n <= 1'b1;
		end
		else
		begin
			// release comes straight from the synced select
			so_oe_n <= !(out_phase && !cs_s[1]);
			so_o    <= out_phase ? out_q[23] : 1'b0;
		end
	end

	// ****************************************
	// delivered contents
	// ****************************************
	// constants after reset, nothing here writes them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			status_q     <= sfid_pkg::STATUS_RESET;
			array_byte_q <= sfid_pkg::ERASED_BYTE;
		end
		else
		begin
			status_q     <= status_q;
			array_byte_q <= array_byte_q;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_desel;
		$rose(cs_s[1]);
	endsequence
	// deselect must release the pin within one clock
	property p_stop;
		@(posedge clk) disable iff (!rstn)
		s_desel |-> ##1 so_oe_n;
	endproperty
	a_stop: assert property (p_stop)
		else $error("output still driven after deselect");
	// standby entered on every deselect
	property p_standby;
		@(posedge clk) disable iff (!rstn)
		!sel |=> st_q == sfid_pkg::SFID_OPC && cnt_q == 5'h00;
	endproperty
	a_standby: assert property (p_standby)
		else $error("not back in standby after deselect");
	// busy at the decoding edge forbids the identity phase
	property p_busy;
		@(posedge clk) disable iff (!rstn)
		busy |=> !(st_q == sfid_pkg::SFID_OUT_ID
			&& $past(st_q) == sfid_pkg::SFID_OPC);
	endproperty
	a_busy: assert property (p_busy)
		else $error("full id decoded while busy");
	property p_idload;
		@(posedge clk) disable iff (!rstn)
		(st_q == sfid_pkg::SFID_OUT_ID
			&& $past(st_q) == sfid_pkg::SFID_OPC)
		|-> out_q == {MAKER_CODE, MEM_TYPE, MEM_CAP};
	endproperty
	a_idload: assert property (p_idload)
		else $error("identity word wrong");
	property p_mpload;
		@(posedge clk) disable iff (!rstn)
		(st_q == sfid_pkg::SFID_OUT_MP
			&& $past(st_q) == sfid_pkg::SFID_ADDR)
		|-> out_q[23:16] == (part_first_q ? PART_CODE : MAKER_CODE);
	endproperty
	a_mpload: assert property (p_mpload)
		else $error("first byte of pair wrong");
	property p_shift;
		@(posedge clk) disable iff (!rstn)
		(sel && fall && !lead_q && st_q == sfid_pkg::SFID_OUT_ID)
		|=> out_q[23] == $past(out_q[22]);
	endproperty
	a_shift: assert property (p_shift)
		else $error("identity not shifted on falling edge");
	property p_drive;
		@(posedge clk) disable iff (!rstn)
		out_phase && sel |=> !so_oe_n || !sel;
	endproperty
	a_drive: assert property (p_drive)
		else $error("output not driven in output phase");
	// opcode bits counted one per rising edge
	property p_count;
		@(posedge clk) disable iff (!rstn)
		(st_q == sfid_pkg::SFID_OPC && sel && rise)
		|=> cnt_q == $past(cnt_q) + 5'h01 || cnt_q == 5'h00;
	endproperty
	a_count: assert property (p_count)
		else $error("opcode bit not counted on rising edge");
	// delivered contents never move after reset
	property p_status;
		@(posedge clk) disable iff (!rstn)
		status_q == sfid_pkg::STATUS_RESET
			&& array_byte_q == sfid_pkg::ERASED_BYTE;
	endproperty
	a_status: assert property (p_status)
		else $error("delivered contents wrong");
	// the lead fall keeps the first bit on the pin
	sequence s_lead_fall;
		sel && fall && lead_q && out_phase;
	endsequence
	property p_lead;
		@(posedge clk) disable iff (!rstn)
		s_lead_fall |=> $stable(out_q);
	endproperty
	a_lead: assert property (p_lead)
		else $error("first output bit moved by the lead fall");
	// the pair comes round again after sixteen bits
	property p_wrap;
		@(posedge clk) disable iff (!rstn)
		(sel && fall && !lead_q && st_q == sfid_pkg::SFID_OUT_MP
			&& cnt_q[3:0] == 4'hf)
		|=> out_q[23:8] == mp_pair(part_first_q);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("maker and part pair not repeated");
endmodule
`default_nettype wire

// ### sfid_pkg.sv
// constants for the serial flash identification read-out block
package sfid_pkg;
	// command codes
	localparam logic [7:0] CMD_MAKER_PART = 8'h90;
	localparam logic [7:0] CMD_FULL_ID    = 8'h9f;
	// bit counts
	localparam int OPCODE_BITS = 8;
	localparam int ADDR_BITS   = 24;
	localparam int ID_BITS     = 24;
	// delivered contents
	localparam logic [7:0] ERASED_BYTE  = 8'hff;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// identity defaults, values are arbitrary
	localparam logic [7:0] DEF_MAKER    = 8'h5a;
	localparam logic [7:0] DEF_TYPE     = 8'h40;
	localparam logic [7:0] DEF_CAPACITY = 8'h10;
	localparam logic [7:0] DEF_PART     = 8'h0f;
	// phases of a selection
	typedef enum logic [2:0] {
		SFID_OPC,
		SFID_ADDR,
		SFID_OUT_MP,
		SFID_OUT_ID,
		SFID_IGNORE
	} sfid_state_t;
endpackage

// ### sfid_host.sv
// host serial controller model for the identification link
`timescale 1ns/1ps
`default_nettype none
module sfid_host (
	// system
	input  wire logic clk,
	// link pins
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic si,
	input  wire logic so_o,
	input  wire logic so_oe_n
);
	// idle: deselected, clock parked low between frames
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	// one selection: ntx bits out msb first, then nrx bits read back
	task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
		output logic [31:0] rx, output logic [31:0] oe);
		rx = '0;
		oe = '0;
		@(posedge clk) cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < ntx + nrx; i++)
		begin
			// toggle si when unused so a stale level never looks valid
			si <= (i < ntx) ? tx[ntx-1-i] : ~si;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			// read just before the fall, well after the sync delay
			if (i >= ntx)
			begin
				rx = {rx[30:0], so_o};
				oe = {oe[30:0], so_oe_n};
			end
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		si   <= ~si;
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### sfid_readout_test.sv
// self-checking bench for the identification read-out
`timescale 1ns/1ps
`default_nettype none
module sfid_readout_test;
	logic        clk;
	logic        rstn;
	logic        busy;
	wire         cs_n, sclk, si, so_o, so_oe_n;
	wire  [7:0]  status_q, array_byte_q;
	logic [31:0] rx, oe;
	int          num_errors = 0;
	int          n_tests = 0;
	// 20 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	sfid_readout DUT (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
		.si(si), .so_o(so_o), .so_oe_n(so_oe_n), .busy(busy),
		.status_q(status_q), .array_byte_q(array_byte_q));
	sfid_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
		.so_o(so_o), .so_oe_n(so_oe_n));
	// compare and count
	task automatic chk(input string name, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// delivered contents and idle output
	task automatic t_reset();
		chk("status", 32'h0, {24'h0, status_q});
		chk("array", 32'hff, {24'h0, array_byte_q});
		chk("oe idle", 32'h1, {31'h0, so_oe_n});
	endtask
	// host gives up after five output bits
	task automatic t_abort();
		host.xfer(32'h9f, 8, 5, rx, oe);
		chk("partial", {27'h0, sfid_pkg::DEF_MAKER[7:3]}, rx);
		chk("stopped", 32'h1, {31'h0, so_oe_n});
	endtask
	// full identification twice, back to back
	task automatic t_full_id();
		logic [31:0] exp;
		exp = {8'h0, sfid_pkg::DEF_MAKER, sfid_pkg::DEF_TYPE,
			sfid_pkg::DEF_CAPACITY};
		repeat (2)
		begin
			host.xfer(32'h9f, 8, 24, rx, oe);
			chk("full id", exp, rx);
			chk("full id oe", 32'h0, oe);
			chk("released", 32'h1, {31'h0, so_oe_n});
		end
	endtask
	// both byte orders; the second one also while busy
	task automatic t_maker_part();
		for (int a = 0; a < 2; a++)
		begin
			@(posedge clk) busy <= (a == 1);
			host.xfer({8'h90, 24'(a)}, 32, 16, rx, oe);
			chk("maker part", a ? {16'h0, sfid_pkg::DEF_PART,
				sfid_pkg::DEF_MAKER} : {16'h0, sfid_pkg::DEF_MAKER,
				sfid_pkg::DEF_PART}, rx);
		end
		@(posedge clk) busy <= 1'b0;
	endtask
	// full id while busy and an unknown opcode stay silent
	task automatic t_refused();
		@(posedge clk) busy <= 1'b1;
		host.xfer(32'h9f, 8, 16, rx, oe);
		chk("busy silent", 32'hffff, oe);
		@(posedge clk) busy <= 1'b0;
		host.xfer(32'h03, 8, 16, rx, oe);
		chk("unknown silent", 32'hffff, oe);
	endtask
	// main sequence
	initial
	begin
		rstn = 1'b0;
		busy = 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_abort();
		t_full_id();
		t_maker_part();
		t_refused();
		conclude();
	end
	// watchdog, about ten times the expected run
	initial
	begin
		#1000000;
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire
